// file: core/emr_energy_meter_readback.sv
/*
 * energy meter readback: status, energy accumulators and telemetry readback.
 * assumes samples, comparator results and command codes arrive synchronous to SYS_CLK.
 */
// Overview of operation
// - aux overvoltage sets bit 6, latched
// - aux undervoltage sets bit 5, latched
// - status bits 7 and 4..0 read zero
// - forward energy read is one snapshot
// - forward accumulates only on positive current
// - reverse accumulates only on negative current
// - reverse energy read is one snapshot
// - shared sample count in bits 47..24
// - forward wrap tally counts accumulator wraps
// - reverse wrap tally counts accumulator wraps
// - forward total is top 16 accumulator bits
// - reverse total is top 16 accumulator bits
// - extended reads return full 24-bit accumulators
// - input voltage in 11..0, upper zero
// - output current read, resets zero
// - VENDOR_SUMMARY_FLAG output when status active
`timescale 1ns/10ps
`default_nettype none
module emr_energy_meter_readback #(
    parameter bit SIGNED_VARIANT = 1'b0
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire emr_pkg::emr_sample_t SAMPLE,
    input wire logic [11:0] INPUT_VOLTAGE,
    input wire logic AUX_ABOVE_OV_THRESHOLD,
    input wire logic AUX_BELOW_UV_THRESHOLD,
    input wire logic STATUS_CLEAR,
    input wire emr_pkg::emr_req_t REQ,
    output var emr_pkg::emr_rsp_t RSP,
    output logic VENDOR_SUMMARY_FLAG
);
    import emr_pkg::*;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    // magnitude of a twos complement current-scaled power sample
    function automatic logic [15:0] magnitude(input logic [15:0] v);
        magnitude = v[15] ? 16'(-v) : v;
    endfunction : magnitude

    // accumulator step; the wrap point moves down for the signed variant
    function automatic logic [ACC_W:0] acc_step(input logic [ACC_W-1:0] acc, input logic [15:0] add);
        logic [ACC_W:0] sum;
        sum = {1'b0, acc} + {9'h000, add};
        if (SIGNED_VARIANT) begin
            acc_step = {sum[ACC_W-1], 1'b0, sum[ACC_W-2:0]};
        end else begin
            acc_step = sum;
        end
    endfunction : acc_step

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    logic aux_overvoltage_warning_reg, aux_overvoltage_warning_next;
    logic aux_undervoltage_warning_reg, aux_undervoltage_warning_next;
    logic [SAMPLE_W-1:0] sample_count_reg, sample_count_next;
    logic [ACC_W-1:0] fwd_acc_reg, fwd_acc_next;
    logic [ACC_W-1:0] rev_acc_reg, rev_acc_next;
    logic [WRAP_W-1:0] forward_wrap_tally_reg, forward_wrap_tally_next;
    logic [WRAP_W-1:0] reverse_wrap_tally_reg, reverse_wrap_tally_next;
    logic [15:0] output_current_reg;
    logic [VIN_W-1:0] input_voltage_reg;
    emr_rsp_t rsp_reg, rsp_next;
    emr_state_t state_reg, state_next;

    // -------------------------------------------------------------------------
    // warnings
    // -------------------------------------------------------------------------
    // latch overvoltage warning; set beats clear
    assign aux_overvoltage_warning_next = AUX_ABOVE_OV_THRESHOLD |
        (aux_overvoltage_warning_reg & ~STATUS_CLEAR);
    // latch undervoltage warning; set beats clear
    assign aux_undervoltage_warning_next = AUX_BELOW_UV_THRESHOLD |
        (aux_undervoltage_warning_reg & ~STATUS_CLEAR);

    wire [7:0] aux_status;
    assign aux_status = {1'b0, aux_overvoltage_warning_reg, aux_undervoltage_warning_reg, 5'h00};
    assign VENDOR_SUMMARY_FLAG = |aux_status;

    // -------------------------------------------------------------------------
    // energy accumulation
    // -------------------------------------------------------------------------
    wire cur_positive = ~SAMPLE.current[15] & (|SAMPLE.current);
    wire cur_negative = SAMPLE.current[15];
    wire [15:0] power_mag = magnitude(SAMPLE.power);
    wire [ACC_W:0] fwd_sum = acc_step(fwd_acc_reg, power_mag);
    wire [ACC_W:0] rev_sum = acc_step(rev_acc_reg, power_mag);
    wire fwd_add = SAMPLE.valid & cur_positive;
    wire rev_add = SAMPLE.valid & cur_negative;

    assign sample_count_next = SAMPLE.valid ? SAMPLE_W'(sample_count_reg + 1'b1) : sample_count_reg;
    assign fwd_acc_next = fwd_add ? fwd_sum[ACC_W-1:0] : fwd_acc_reg;
    assign rev_acc_next = rev_add ? rev_sum[ACC_W-1:0] : rev_acc_reg;
    assign forward_wrap_tally_next = (fwd_add & fwd_sum[ACC_W]) ?
        WRAP_W'(forward_wrap_tally_reg + 1'b1) : forward_wrap_tally_reg;
    assign reverse_wrap_tally_next = (rev_add & rev_sum[ACC_W]) ?
        WRAP_W'(reverse_wrap_tally_reg + 1'b1) : reverse_wrap_tally_reg;

    // -------------------------------------------------------------------------
    // read decode
    // -------------------------------------------------------------------------
    // forward total is upper accumulator bits
    wire [TOTAL_W-1:0] forward_energy_total = fwd_acc_reg[ACC_W-1 -: TOTAL_W];
    // reverse total is upper accumulator bits
    wire [TOTAL_W-1:0] reverse_energy_total = rev_acc_reg[ACC_W-1 -: TOTAL_W];
    wire [DATA_W-1:0] fwd_word = {sample_count_reg, forward_wrap_tally_reg, forward_energy_total};
    wire [DATA_W-1:0] rev_word = {sample_count_reg, reverse_wrap_tally_reg, reverse_energy_total};

    always_comb begin
        rsp_next = '0;
        rsp_next.valid = REQ.valid;
        rsp_next.known = 1'b1;
        case (REQ.code)
            CMD_AUX_STATUS: rsp_next.data = {40'h0000000000, aux_status};
            // whole forward word in one capture
            CMD_FWD_ENERGY: rsp_next.data = fwd_word;
            // whole reverse word in one capture
            CMD_REV_ENERGY: rsp_next.data = rev_word;
            // registered input voltage, top bits zero
            CMD_VIN: rsp_next.data = {36'h000000000, input_voltage_reg};
            CMD_OUTPUT_CURRENT: rsp_next.data = {32'h00000000, output_current_reg};
            CMD_FWD_FULL: rsp_next.data = {24'h000000, fwd_acc_reg};
            CMD_REV_FULL: rsp_next.data = {24'h000000, rev_acc_reg};
            default: begin
                rsp_next.known = 1'b0;
                rsp_next.data = DATA_ZERO;
            end
        endcase
        if (!REQ.valid) begin
            rsp_next = '0;
        end
    end

    always_comb begin
        case (state_reg)
            EMR_IDLE: state_next = REQ.valid ? EMR_ANSWER : EMR_IDLE;
            EMR_ANSWER: state_next = REQ.valid ? EMR_ANSWER : EMR_IDLE;
            default: state_next = EMR_IDLE;
        endcase
    end

    assign RSP = rsp_reg;

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            aux_overvoltage_warning_reg <= 1'b0;
            aux_undervoltage_warning_reg <= 1'b0;
            sample_count_reg <= ACC_ZERO;
            fwd_acc_reg <= ACC_ZERO;
            rev_acc_reg <= ACC_ZERO;
            forward_wrap_tally_reg <= 8'h00;
            reverse_wrap_tally_reg <= 8'h00;
            output_current_reg <= 16'h0000;
            input_voltage_reg <= 12'h000;
            rsp_reg <= '0;
            state_reg <= EMR_IDLE;
        end else if (CLK_EN) begin
            aux_overvoltage_warning_reg <= aux_overvoltage_warning_next;
            aux_undervoltage_warning_reg <= aux_undervoltage_warning_next;
            sample_count_reg <= sample_count_next;
            fwd_acc_reg <= fwd_acc_next;
            rev_acc_reg <= rev_acc_next;
            forward_wrap_tally_reg <= forward_wrap_tally_next;
            reverse_wrap_tally_reg <= reverse_wrap_tally_next;
            if (SAMPLE.valid) begin
                output_current_reg <= SAMPLE.current;
            end
            input_voltage_reg <= INPUT_VOLTAGE;
            rsp_reg <= rsp_next;
            state_reg <= state_next;
        end
    end
endmodule : emr_energy_meter_readback
`default_nettype wire

// file: core/emr_pkg.sv
/*
 * constants, command codes and carrier types of the energy meter readback block.
 * assumes a serial target engine outside that decodes command codes and shifts bytes.
 */
`default_nettype none
package emr_pkg;
    // -------------------------------------------------------------------------
    // command codes
    // -------------------------------------------------------------------------
    localparam logic [7:0] CMD_AUX_STATUS = 8'h80;
    localparam logic [7:0] CMD_FWD_ENERGY = 8'h86;
    localparam logic [7:0] CMD_REV_ENERGY = 8'h87;
    localparam logic [7:0] CMD_VIN = 8'h88;
    localparam logic [7:0] CMD_OUTPUT_CURRENT = 8'h8c;
    // chosen codes for the full-width accumulator reads
    localparam logic [7:0] CMD_FWD_FULL = 8'hdc;
    localparam logic [7:0] CMD_REV_FULL = 8'hdd;

    // -------------------------------------------------------------------------
    // field layout
    // -------------------------------------------------------------------------
    localparam int OV_BIT = 6;
    localparam int UV_BIT = 5;
    localparam int SUMMARY_BIT = 12;
    localparam int ACC_W = 24;
    localparam int TOTAL_W = 16;
    localparam int WRAP_W = 8;
    localparam int SAMPLE_W = 24;
    localparam int VIN_W = 12;
    localparam int DATA_W = 48;
    localparam logic [ACC_W-1:0] ACC_ZERO = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 48'h000000000000;

    // one power sample from the measurement path
    typedef struct packed {
        logic valid;
        logic [15:0] power;
        logic [15:0] current;
    } emr_sample_t;

    // one read request and its answer
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } emr_req_t;

    typedef struct packed {
        logic valid;
        logic known;
        logic [DATA_W-1:0] data;
    } emr_rsp_t;

    typedef enum logic [1:0] {
        EMR_IDLE = 2'b00,
        EMR_ANSWER = 2'b01
    } emr_state_t;
endpackage : emr_pkg
`default_nettype wire

// file: tb/emr_chk.sv
/* checker: answer timing, status latching and zero fields of the readback block.
   assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module emr_chk (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic AUX_ABOVE_OV_THRESHOLD,
    input wire logic AUX_BELOW_UV_THRESHOLD,
    input wire logic STATUS_CLEAR,
    input wire emr_pkg::emr_req_t REQ,
    input wire emr_pkg::emr_rsp_t RSP,
    input wire logic VENDOR_SUMMARY_FLAG
);
    import emr_pkg::*;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    wire logic take = REQ.valid && CLK_EN;
    wire logic flag = VENDOR_SUMMARY_FLAG;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    rsp_follows_a:
    assert property (take |=> RSP.valid) else $error("read not answered");
    idle_quiet_a:
    assert property (!REQ.valid && CLK_EN |=> !RSP.valid) else $error("answer without read");
    ov_sets_a:
    assert property (AUX_ABOVE_OV_THRESHOLD && CLK_EN |=> flag) else $error("overvoltage not flagged");
    uv_sets_a:
    assert property (AUX_BELOW_UV_THRESHOLD && CLK_EN |=> flag) else $error("undervoltage not flagged");
    warn_hold_a:
    assert property (flag && !STATUS_CLEAR |=> flag) else $error("warning dropped");
    reset_clear_a:
    assert property ($past(SYS_RST) |-> !flag) else $error("flag after reset");
    stat_zero_a:
    assert property (take && REQ.code == CMD_AUX_STATUS |=> RSP.data[47:7] == '0 && RSP.data[4:0] == '0)
        else $error("status reserved bits set");
    vin_top_a:
    assert property (take && REQ.code == CMD_VIN |=> RSP.data[47:12] == '0) else $error("vin upper bits set");
endmodule : emr_chk
`default_nettype wire

// file: tb/emr_energy_meter_readback_bench.sv
/* bench: random and corner stimulus with a reference model of the accumulators.
   assumes the package, host model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module emr_energy_meter_readback_bench;
    import emr_pkg::*;
    logic SYS_CLK = 1'b0, SYS_RST = 1'b1, CLK_EN = 1'b1, ov = 1'b0, uv = 1'b0, clr = 1'b0, flag;
    logic [11:0] input_voltage = 12'h000, v;
    emr_sample_t smp = '0;
    emr_req_t req;
    emr_rsp_t rsp, r, rsp2;
    // reference of the signed variant, which wraps its accumulators one bit lower
    logic [23:0] facc2 = '0, racc2 = '0;
    logic [7:0] ftal2 = '0, rtal2 = '0;
    int err_total = 0, checked = 0;
    logic [23:0] cnt = '0, facc = '0, racc = '0;
    logic [7:0] ftal = '0, rtal = '0, ex[7] = '{8'h40, 8'h40, 8'h00, 8'h20, 8'h20, 8'h60, 8'h00};
    logic [15:0] cur = '0;
    logic [2:0] st[7] = '{3'b100, 3'b000, 3'b001, 3'b010, 3'b011, 3'b110, 3'b001};
    logic [7:0] codes[7] = '{CMD_AUX_STATUS, CMD_FWD_ENERGY, CMD_REV_ENERGY, CMD_VIN, CMD_OUTPUT_CURRENT,
        CMD_FWD_FULL, CMD_REV_FULL};
    always #2.5 SYS_CLK = ~SYS_CLK;
    emr_energy_meter_readback emr_energy_meter_readback_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
        .CLK_EN(CLK_EN), .SAMPLE(smp), .INPUT_VOLTAGE(input_voltage), .AUX_ABOVE_OV_THRESHOLD(ov),
        .AUX_BELOW_UV_THRESHOLD(uv), .STATUS_CLEAR(clr), .REQ(req), .RSP(rsp), .VENDOR_SUMMARY_FLAG(flag));
    // second copy in the signed variant sees the same stimulus and requests
    emr_energy_meter_readback #(.SIGNED_VARIANT(1'b1)) emr_energy_meter_readback_signed_inst (.SYS_CLK(SYS_CLK),
        .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .SAMPLE(smp), .INPUT_VOLTAGE(input_voltage), .AUX_ABOVE_OV_THRESHOLD(ov),
        .AUX_BELOW_UV_THRESHOLD(uv), .STATUS_CLEAR(clr), .REQ(req), .RSP(rsp2), .VENDOR_SUMMARY_FLAG());
    emr_host emr_host_inst (.clk(SYS_CLK), .req(req), .rsp(rsp));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cmp(input string n, input logic [48:0] e, input logic [48:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    task automatic rdc(input logic [7:0] c, input logic [48:0] e);
        emr_host_inst.rd(c, r);
        cmp($sformatf("code %h", c), e, {r.known, r.data});
    endtask : rdc
    function automatic logic [48:0] eng(input logic [7:0] t, input logic [23:0] a);
        return {1'b1, cnt, t, a[23:8]};
    endfunction : eng
    task automatic put(input logic [15:0] p, input logic [15:0] c, input logic en);
        logic [16:0] m;
        logic [24:0] s;
        logic [24:0] s2;
        m = p[15] ? 17'h10000 - {1'b0, p} : {1'b0, p};
        @(posedge SYS_CLK);
        smp <= {1'b1, p, c};
        CLK_EN <= en;
        @(posedge SYS_CLK);
        smp <= {1'b0, ~p, ~c};
        CLK_EN <= 1'b1;
        if (en) begin
            cnt++;
            cur = c;
            s = c[15] ? racc + m : facc + m;
            s2 = c[15] ? racc2 + m : facc2 + m;
            if (!c[15] && c != 16'h0) begin
                ftal2 += 8'(s2[23]);
                facc2 = {1'b0, s2[22:0]};
            end else if (c[15]) begin
                rtal2 += 8'(s2[23]);
                racc2 = {1'b0, s2[22:0]};
            end
            if (!c[15] && c != 16'h0) begin
                ftal += 8'(s[24]);
                facc = s[23:0];
            end else if (c[15]) begin
                rtal += 8'(s[24]);
                racc = s[23:0];
            end
        end
    endtask : put
    task automatic summarize;
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #400000;
        err_total++;
        summarize();
    end
    initial begin
        void'($urandom(32'hd0a2a771));
        repeat (2) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        foreach (codes[i]) rdc(codes[i], {1'b1, 48'h0});
        rdc(8'h00, 49'h0);
        $display("test reset done");
        put(16'h7fff, 16'h0000, 1'b1);
        put(16'h8000, 16'h8000, 1'b1);
        for (int i = 0; i < 4000; i++) begin
            put(16'($urandom), (i % 40 == 3) ? 16'h0 : 16'($urandom), i % 97 != 5);
            if (i % 500 == 499) begin
                rdc(CMD_FWD_ENERGY, eng(ftal, facc));
                cmp("signed forward", eng(ftal2, facc2), {rsp2.known, rsp2.data});
                rdc(CMD_REV_ENERGY, eng(rtal, racc));
                cmp("signed reverse", eng(rtal2, racc2), {rsp2.known, rsp2.data});
                rdc(CMD_FWD_FULL, {25'h1000000, facc});
                rdc(CMD_REV_FULL, {25'h1000000, racc});
                rdc(CMD_OUTPUT_CURRENT, {17'h10000, 16'h0, cur});
            end
        end
        $display("test energy done wraps %0d %0d", ftal, rtal);
        foreach (st[i]) begin
            @(posedge SYS_CLK);
            {ov, uv, clr} <= st[i];
            @(posedge SYS_CLK);
            {ov, uv, clr} <= 3'b000;
            rdc(CMD_AUX_STATUS, {1'b1, 40'h0, ex[i]});
            cmp("flag", {48'h0, |ex[i]}, {48'h0, flag});
        end
        $display("test status done");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 12'hfff : 12'($urandom);
            @(posedge SYS_CLK);
            input_voltage <= v;
            rdc(CMD_VIN, {1'b1, 36'h0, v});
        end
        $display("test vin done");
        summarize();
    end
endmodule : emr_energy_meter_readback_bench
bind emr_energy_meter_readback emr_chk emr_chk_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .AUX_ABOVE_OV_THRESHOLD(AUX_ABOVE_OV_THRESHOLD), .AUX_BELOW_UV_THRESHOLD(AUX_BELOW_UV_THRESHOLD),
    .STATUS_CLEAR(STATUS_CLEAR), .REQ(REQ), .RSP(RSP), .VENDOR_SUMMARY_FLAG(VENDOR_SUMMARY_FLAG));
`default_nettype wire

// file: tb/emr_host.sv
/* host model: one read per call, whole 48-bit answer taken at once.
   assumes CLK_EN high while a read runs. */
`timescale 1ns/10ps
`default_nettype none
module emr_host (
    input wire logic clk,
    output var emr_pkg::emr_req_t req,
    input wire emr_pkg::emr_rsp_t rsp
);
    import emr_pkg::*;
    initial req = '0;
    task automatic rd(input logic [7:0] code, output emr_rsp_t r);
        @(posedge clk);
        req <= {1'b1, code};
        @(posedge clk);
        // released code shows inverse so stale values never look valid
        req <= {1'b0, ~code};
        @(posedge clk);
        r = rsp;
    endtask : rd
endmodule : emr_host
`default_nettype wire
